// file: logic/usp_pkg.sv
// Shared constants and types for the SPI register port, both ends
// How it works
// - Full duplex: separate lines, output only when selected
// - Status byte shifts out during command byte
// - Full-duplex read: data out, input ignored
// - Full-duplex write: zeroes out after status
// - Select high: outputs off, port logic reset
// - Half duplex: shared data line, no status
// - Duplex bit 1 full, 0 half; reset half
// - Sample on rising edge, change on falling
// - Clock edges ignored while deselected
// - Whole bytes only; partial byte discarded
// - Master may stop after command byte
// - Most significant bit first, always
// - Master clock up to 26 MHz
// - Clock polarity/phase 0/0 and 1/1 both work
// - On select, first output bit shown immediately
// - Master idles clock before selecting
// - Further byte groups burst while selected
// - Master changes its data on falling edges
// - Command byte, then addressed register data
// - Half-duplex read: master releases, device drives
`default_nettype none
package usp_pkg;
    localparam int          BYTE_BITS     = 8;
    localparam logic [2:0]  LAST_BIT      = 3'h7;
    localparam logic [2:0]  FIRST_BIT     = 3'h0;
    localparam logic [7:0]  ZERO_BYTE     = 8'h00;
    localparam int          ADDR_W        = 5;
    localparam int          ADDR_MSB      = 7;
    localparam int          ADDR_LSB      = 3;
    localparam int          DIR_BIT       = 1;
    localparam logic        DIR_WRITE     = 1'b1;
    localparam logic        DUPLEX_RESET  = 1'b0;
    localparam logic        DUPLEX_FULL   = 1'b1;
    localparam int          PIN_SCLK      = 0;
    localparam int          PIN_SS        = 1;
    localparam int          PIN_DATA      = 2;
    localparam logic [2:0]  PINS_IDLE     = 3'h2;
    localparam int          CLOCK_NS      = 10;
    localparam int          SCLK_NS       = 80;
    localparam int          HALF_INT      = SCLK_NS / (2 * CLOCK_NS);
    localparam logic [3:0]  HALF_LAST     = 4'(HALF_INT - 1);
    localparam logic [3:0]  DIV_ZERO      = 4'h0;
    localparam logic [7:0]  COUNT_ZERO    = 8'h00;
    localparam logic [7:0]  CMD_BITS      = 8'h08;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_LEAD  = 2'b01,
        ST_RUN   = 2'b10,
        ST_TRAIL = 2'b11
    } usp_state_type;
endpackage
`default_nettype wire

// file: logic/usp_if.sv
// Serial link between register port and its master
`timescale 1ns/1ps
`default_nettype none
interface usp_if;
    logic ss_n;
    logic sclk;
    logic mosi_m;
    logic mosi_m_oe;
    logic mosi_d;
    logic mosi_d_oe;
    logic miso;
    logic miso_oe;
    logic mosi_line;
    logic miso_line;

    // Pulled-up shared lines; undriven reads high
    assign mosi_line = mosi_m_oe ? mosi_m : (mosi_d_oe ? mosi_d : 1'b1);
    assign miso_line = miso_oe ? miso : 1'b1;

    modport device (
        input  ss_n, sclk, mosi_line,
        output miso, miso_oe, mosi_d, mosi_d_oe
    );
    modport master (
        input  miso_line, mosi_line,
        output ss_n, sclk, mosi_m, mosi_m_oe
    );
endinterface
`default_nettype wire

// file: logic/usp_device.sv
// Device end of the SPI register port
`timescale 1ns/1ps
`default_nettype none
module usp_device
    import usp_pkg::*;
(
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // Serial link
    usp_if.device                  link,
    // Duplex setting from register file
    input  wire logic              duplex_wr,
    input  wire logic              duplex_wdata,
    output logic                   duplex_select_bit,
    // Status shown during command byte
    input  wire logic [7:0]        status,
    // Decoded command
    output logic                   cmd_valid,
    output logic [ADDR_W-1:0]      cmd_addr,
    output logic                   cmd_write,
    // Write data
    output logic                   wr_valid,
    output logic [7:0]             wr_data,
    // Read data
    output logic                   rd_req,
    input  wire logic [7:0]        rd_data
);

    logic [2:0]            sync1;
    logic [2:0]            sync2;
    logic [1:0]            sync3;
    logic                  selected;
    logic                  sel_fall;
    logic                  sclk_rise;
    logic                  sclk_fall;

    logic [7:0]            in_shift;
    logic [7:0]            next_in_shift;
    logic [2:0]            bit_cnt;
    logic [2:0]            next_bit_cnt;
    logic                  cmd_done;
    logic                  next_cmd_done;
    logic                  is_read;
    logic                  next_is_read;
    logic                  rose;
    logic                  next_rose;
    logic [7:0]            out_shift;
    logic [7:0]            next_out_shift;
    logic                  miso_en;
    logic                  next_miso_en;
    logic                  mosi_en;
    logic                  next_mosi_en;
    logic                  next_duplex;
    logic                  next_cmd_valid;
    logic [ADDR_W-1:0]     next_cmd_addr;
    logic                  next_cmd_write;
    logic                  next_wr_valid;
    logic [7:0]            next_wr_data;
    logic                  next_rd_req;
    logic [7:0]            byte_in;

    // Pins cross in through two flops
    always_ff @(posedge clock) begin
        if (rst) begin
            sync1 <= PINS_IDLE;
            sync2 <= PINS_IDLE;
            sync3 <= PINS_IDLE[1:0];
        end else begin
            sync1 <= {link.mosi_line, link.ss_n, link.sclk};
            sync2 <= sync1;
            sync3 <= sync2[1:0];
        end
    end

    assign selected  = !sync2[PIN_SS];
    assign sel_fall  = sync3[PIN_SS] && !sync2[PIN_SS];
    // Rising edge works for either idle level
    assign sclk_rise = selected && !sync3[PIN_SCLK] && sync2[PIN_SCLK];
    assign sclk_fall = selected && sync3[PIN_SCLK] && !sync2[PIN_SCLK];
    assign byte_in   = {in_shift[6:0], sync2[PIN_DATA]};

    always_comb begin
        next_in_shift  = in_shift;
        next_bit_cnt   = bit_cnt;
        next_cmd_done  = cmd_done;
        next_is_read   = is_read;
        next_rose      = rose;
        next_out_shift = out_shift;
        next_miso_en   = miso_en;
        next_mosi_en   = mosi_en;
        next_duplex    = duplex_select_bit;
        next_cmd_valid = 1'b0;
        next_cmd_addr  = cmd_addr;
        next_cmd_write = cmd_write;
        next_wr_valid  = 1'b0;
        next_wr_data   = wr_data;
        next_rd_req    = 1'b0;
        if (duplex_wr) begin
            next_duplex = duplex_wdata;
        end
        if (!selected) begin
            // Deselect clears the whole serial state
            next_in_shift  = ZERO_BYTE;
            next_bit_cnt   = FIRST_BIT;
            next_cmd_done  = 1'b0;
            next_is_read   = 1'b0;
            next_rose      = 1'b0;
            next_out_shift = ZERO_BYTE;
            next_miso_en   = 1'b0;
            next_mosi_en   = 1'b0;
        end else if (sel_fall) begin
            // First bit shown before any clock edge
            // Output driven only in full duplex
            next_miso_en = (duplex_select_bit == DUPLEX_FULL);
            // Status loaded for the command byte
            next_out_shift = next_miso_en ? status : ZERO_BYTE;
        end else if (sclk_rise) begin
            // Input sampled on the rising edge
            next_in_shift = byte_in;
            next_bit_cnt  = bit_cnt + 3'h1;
            next_rose     = 1'b1;
            if (bit_cnt == LAST_BIT) begin
                if (!cmd_done) begin
                    // Command split into address and direction
                    next_cmd_done  = 1'b1;
                    next_cmd_valid = 1'b1;
                    next_cmd_addr  = byte_in[ADDR_MSB:ADDR_LSB];
                    next_cmd_write = (byte_in[DIR_BIT] == DIR_WRITE);
                    next_is_read   = (byte_in[DIR_BIT] != DIR_WRITE);
                    next_rd_req    = (byte_in[DIR_BIT] != DIR_WRITE);
                end else if (is_read) begin
                    // Each burst byte asks for more data
                    next_rd_req = 1'b1;
                end else begin
                    next_wr_valid = 1'b1;
                    next_wr_data  = byte_in;
                end
            end
        end else if (sclk_fall && rose) begin
            // Output changes on falling edge only
            // Falls before the first rise leave the first bit alone
            next_rose = 1'b0;
            if (bit_cnt == FIRST_BIT && cmd_done) begin
                next_out_shift = is_read ? rd_data : ZERO_BYTE;
                // Shared line driven for half-duplex reads
                // Shared line taken only for read data
                next_mosi_en = !miso_en && is_read;
            end else begin
                next_out_shift = {out_shift[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            in_shift          <= ZERO_BYTE;
            bit_cnt           <= FIRST_BIT;
            cmd_done          <= 1'b0;
            is_read           <= 1'b0;
            rose              <= 1'b0;
            out_shift         <= ZERO_BYTE;
            miso_en           <= 1'b0;
            mosi_en           <= 1'b0;
            duplex_select_bit <= DUPLEX_RESET;
            cmd_valid         <= 1'b0;
            cmd_addr          <= ZERO_BYTE[ADDR_W-1:0];
            cmd_write         <= 1'b0;
            wr_valid          <= 1'b0;
            wr_data           <= ZERO_BYTE;
            rd_req            <= 1'b0;
        end else begin
            in_shift          <= next_in_shift;
            bit_cnt           <= next_bit_cnt;
            cmd_done          <= next_cmd_done;
            is_read           <= next_is_read;
            rose              <= next_rose;
            out_shift         <= next_out_shift;
            miso_en           <= next_miso_en;
            mosi_en           <= next_mosi_en;
            duplex_select_bit <= next_duplex;
            cmd_valid         <= next_cmd_valid;
            cmd_addr          <= next_cmd_addr;
            cmd_write         <= next_cmd_write;
            wr_valid          <= next_wr_valid;
            wr_data           <= next_wr_data;
            rd_req            <= next_rd_req;
        end
    end

    // One shifter feeds whichever data line is active
    assign link.miso      = out_shift[7];
    assign link.miso_oe   = miso_en;
    assign link.mosi_d    = out_shift[7];
    assign link.mosi_d_oe = mosi_en;

endmodule // usp_device
`default_nettype wire

// file: logic/usp_master.sv
// Master end of the SPI register port
`timescale 1ns/1ps
`default_nettype none
module usp_master
    import usp_pkg::*;
(
    // Clock and reset
    input  wire logic          clock,
    input  wire logic          rst,
    // Serial link
    usp_if.master              link,
    // Access request
    input  wire logic          start,
    input  wire logic          cpol,
    input  wire logic          full_duplex,
    input  wire logic          read_access,
    input  wire logic [7:0]    cmd_byte,
    input  wire logic [3:0]    data_len,
    output logic               busy,
    // Write data
    input  wire logic [7:0]    tx_data,
    output logic               tx_req,
    // Received bytes
    output logic               rx_valid,
    output logic [7:0]         rx_data
);

    usp_state_type         state;
    usp_state_type         next_state;
    logic [1:0]            sync1;
    logic [1:0]            sync2;
    logic [3:0]            div;
    logic [3:0]            next_div;
    logic                  sclk;
    logic                  next_sclk;
    logic                  ss_n;
    logic                  next_ss_n;
    logic                  oe;
    logic                  next_oe;
    logic [7:0]            tx_shift;
    logic [7:0]            next_tx_shift;
    logic [2:0]            tx_cnt;
    logic [2:0]            next_tx_cnt;
    logic [7:0]            rx_shift;
    logic [7:0]            next_rx_shift;
    logic [2:0]            rx_cnt;
    logic [2:0]            next_rx_cnt;
    logic [7:0]            rises;
    logic [7:0]            next_rises;
    logic [7:0]            total;
    logic [7:0]            next_total;
    logic                  after_rise;
    logic                  next_after_rise;
    logic                  half_mode;
    logic                  next_half_mode;
    logic                  rd_mode;
    logic                  next_rd_mode;
    logic                  next_busy;
    logic                  next_tx_req;
    logic                  next_rx_valid;
    logic [7:0]            next_rx_data;
    logic                  tick;
    logic [4:0]            byte_total;

    // Divider keeps link clock under limit
    assign tick       = (div == HALF_LAST);
    assign byte_total = 5'(data_len) + 5'h1;

    always_ff @(posedge clock) begin
        if (rst) begin
            sync1 <= 2'h3;
            sync2 <= 2'h3;
        end else begin
            sync1 <= {link.mosi_line, link.miso_line};
            sync2 <= sync1;
        end
    end

    always_comb begin
        next_state      = state;
        next_div        = tick ? DIV_ZERO : div + 4'h1;
        next_sclk       = sclk;
        next_ss_n       = ss_n;
        next_oe         = oe;
        next_tx_shift   = tx_shift;
        next_tx_cnt     = tx_cnt;
        next_rx_shift   = rx_shift;
        next_rx_cnt     = rx_cnt;
        next_rises      = rises;
        next_total      = total;
        next_after_rise = after_rise;
        next_half_mode  = half_mode;
        next_rd_mode    = rd_mode;
        next_busy       = busy;
        next_tx_req     = 1'b0;
        next_rx_valid   = 1'b0;
        next_rx_data    = rx_data;
        case (state)
            ST_IDLE: begin
                next_div  = DIV_ZERO;
                // Clock parked at idle before select
                next_sclk = cpol;
                if (start) begin
                    // First bit placed before select falls
                    // Select waits a cycle so a new idle level settles
                    next_state     = ST_LEAD;
                    next_oe        = 1'b1;
                    next_busy      = 1'b1;
                    next_tx_shift  = cmd_byte;
                    next_tx_cnt    = FIRST_BIT;
                    next_rx_cnt    = FIRST_BIT;
                    next_rises     = COUNT_ZERO;
                    next_total     = {byte_total, 3'h0};
                    next_half_mode = !full_duplex;
                    next_rd_mode   = read_access;
                    next_after_rise = 1'b0;
                end
            end
            ST_LEAD: begin
                next_ss_n = 1'b0;
                if (tick) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (tick) begin
                    if (after_rise) begin
                        // Sample a full half period after the rise
                        next_after_rise = 1'b0;
                        next_rx_shift = {rx_shift[6:0], sync2[half_mode ? 1 : 0]};
                        next_rx_cnt   = rx_cnt + 3'h1;
                        if (rx_cnt == LAST_BIT) begin
                            next_rx_valid = 1'b1;
                            next_rx_data  = next_rx_shift;
                        end
                        if (half_mode && rd_mode && rises == CMD_BITS) begin
                            next_oe = 1'b0;
                        end
                    end
                    if (after_rise && rises == total) begin
                        // Ends at a byte boundary only
                        next_sclk  = cpol;
                        next_state = ST_TRAIL;
                    end else begin
                        next_sclk = !sclk;
                        if (!sclk) begin
                            next_rises      = rises + 8'h01;
                            next_after_rise = 1'b1;
                        end else if (rises != COUNT_ZERO) begin
                            next_tx_cnt = tx_cnt + 3'h1;
                            if (tx_cnt == LAST_BIT) begin
                                next_tx_shift = tx_data;
                                next_tx_req   = 1'b1;
                            end else begin
                                next_tx_shift = {tx_shift[6:0], 1'b0};
                            end
                        end
                    end
                end
            end
            ST_TRAIL: begin
                if (tick) begin
                    next_ss_n  = 1'b1;
                    next_oe    = 1'b0;
                    next_busy  = 1'b0;
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state      <= ST_IDLE;
            div        <= DIV_ZERO;
            sclk       <= 1'b0;
            ss_n       <= 1'b1;
            oe         <= 1'b0;
            tx_shift   <= ZERO_BYTE;
            tx_cnt     <= FIRST_BIT;
            rx_shift   <= ZERO_BYTE;
            rx_cnt     <= FIRST_BIT;
            rises      <= COUNT_ZERO;
            total      <= COUNT_ZERO;
            after_rise <= 1'b0;
            half_mode  <= 1'b1;
            rd_mode    <= 1'b0;
            busy       <= 1'b0;
            tx_req     <= 1'b0;
            rx_valid   <= 1'b0;
            rx_data    <= ZERO_BYTE;
        end else begin
            state      <= next_state;
            div        <= next_div;
            sclk       <= next_sclk;
            ss_n       <= next_ss_n;
            oe         <= next_oe;
            tx_shift   <= next_tx_shift;
            tx_cnt     <= next_tx_cnt;
            rx_shift   <= next_rx_shift;
            rx_cnt     <= next_rx_cnt;
            rises      <= next_rises;
            total      <= next_total;
            after_rise <= next_after_rise;
            half_mode  <= next_half_mode;
            rd_mode    <= next_rd_mode;
            busy       <= next_busy;
            tx_req     <= next_tx_req;
            rx_valid   <= next_rx_valid;
            rx_data    <= next_rx_data;
        end
    end

    assign link.sclk      = sclk;
    assign link.ss_n      = ss_n;
    assign link.mosi_m    = tx_shift[7];
    assign link.mosi_m_oe = oe;

endmodule // usp_master
`default_nettype wire

// file: test/usp_asserts.sv
// Protocol checks on the link between master and device ends
`timescale 1ns/1ps
`default_nettype none
module usp_asserts (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Link signals
    input wire logic ss_n,
    input wire logic sclk,
    input wire logic mosi_m,
    input wire logic mosi_m_oe,
    input wire logic mosi_d_oe,
    input wire logic miso,
    input wire logic miso_oe
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    a_miso_off_idle: assert property (ss_n [*4] |-> !miso_oe)
        else $error("miso driven while deselected");
    a_shared_off_idle: assert property (ss_n [*4] |-> !mosi_d_oe)
        else $error("shared line driven while deselected");
    a_one_output_mode: assert property (!(miso_oe && mosi_d_oe))
        else $error("both device outputs enabled");
    a_no_line_fight: assert property (!(mosi_m_oe && mosi_d_oe))
        else $error("shared line driven by both ends");
    a_first_bit_early: assert property ($rose(miso_oe) |-> !ss_n
        && ($past(ss_n, 3) || $past(ss_n, 4) || $past(ss_n, 5)))
        else $error("miso enable not tied to select");
    a_miso_on_fall: assert property ($changed(miso) && miso_oe && $past(miso_oe)
        |-> $past(sclk, 4) && !$past(sclk, 3))
        else $error("miso changed away from falling clock");
    a_master_on_fall: assert property ($changed(mosi_m) && mosi_m_oe
        && $past(mosi_m_oe) && !ss_n |-> !sclk)
        else $error("master data changed with clock high");
    a_clock_idle_select: assert property ($fell(ss_n) |-> $stable(sclk) [*4])
        else $error("clock not idle at select");
    a_shared_after_cmd: assert property ($rose(mosi_d_oe) |-> !ss_n && !$past(ss_n, 60))
        else $error("device drove shared line too early");
    a_release_handover: assert property ($fell(mosi_m_oe) && !ss_n
        |-> ##[1:8] mosi_d_oe)
        else $error("device did not take the shared line");

    c_full_frame: cover property ($rose(miso_oe));
    c_half_read: cover property ($rose(mosi_d_oe));
    c_release: cover property ($fell(mosi_m_oe) && !ss_n);
endmodule // usp_asserts
`default_nettype wire

// file: test/testbench.sv
// Bench joining master and device ends of the SPI register port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import usp_pkg::*;
    logic              clock = 1'b0;
    logic              rst, start, cpol, full_duplex, read_access, duplex_wr, duplex_wdata;
    logic [7:0]        cmd_byte, tx_data, status, rd_data, rx_data, wr_data;
    logic [3:0]        data_len;
    logic              busy, tx_req, rx_valid, duplex_select_bit, cmd_valid, cmd_write;
    logic              wr_valid, rd_req, seen_write;
    logic [ADDR_W-1:0] cmd_addr, seen_addr;
    logic [7:0]        rx_q[$], wr_q[$];
    int                fails = 0, checks = 0, cmd_seen, oe_cycles;

    usp_if link_if ();
    usp_device usp_device_inst (.clock(clock), .rst(rst), .link(link_if.device),
        .duplex_wr(duplex_wr), .duplex_wdata(duplex_wdata),
        .duplex_select_bit(duplex_select_bit), .status(status), .cmd_valid(cmd_valid),
        .cmd_addr(cmd_addr), .cmd_write(cmd_write), .wr_valid(wr_valid), .wr_data(wr_data),
        .rd_req(rd_req), .rd_data(rd_data));
    usp_master usp_master_inst (.clock(clock), .rst(rst), .link(link_if.master),
        .start(start), .cpol(cpol), .full_duplex(full_duplex), .read_access(read_access),
        .cmd_byte(cmd_byte), .data_len(data_len), .busy(busy), .tx_data(tx_data),
        .tx_req(tx_req), .rx_valid(rx_valid), .rx_data(rx_data));
    usp_asserts usp_asserts_inst (.clock(clock), .rst(rst), .ss_n(link_if.ss_n),
        .sclk(link_if.sclk), .mosi_m(link_if.mosi_m), .mosi_m_oe(link_if.mosi_m_oe),
        .mosi_d_oe(link_if.mosi_d_oe), .miso(link_if.miso), .miso_oe(link_if.miso_oe));

    always #5 clock = ~clock;

    // Sample settled outputs; feed data sources on their requests
    always @(negedge clock) begin
        if (rx_valid === 1'b1) rx_q.push_back(rx_data);
        if (wr_valid === 1'b1) wr_q.push_back(wr_data);
        if (link_if.miso_oe === 1'b1) oe_cycles++;
        if (cmd_valid === 1'b1) begin
            cmd_seen++;
            seen_addr = cmd_addr;
            seen_write = cmd_write;
        end
        if (rd_req === 1'b1) rd_data <= rd_data + 8'h35;
        if (tx_req === 1'b1) tx_data <= tx_data + 8'h29;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic set_duplex(input logic v);
        @(negedge clock);
        duplex_wr = 1'b1;
        duplex_wdata = v;
        @(negedge clock);
        duplex_wr = 1'b0;
        check("duplex bit", {7'h0, duplex_select_bit}, {7'h0, v});
    endtask

    // One register access through the master, then compare both user sides
    task automatic access(input logic fd, input logic pol, input logic rd,
                          input logic [7:0] cmd, input logic [3:0] len);
        logic [7:0] t0, r0;
        int n;
        @(negedge clock);
        full_duplex = fd;
        cpol = pol;
        read_access = rd;
        cmd_byte = cmd;
        data_len = len;
        status = ~cmd;
        t0 = tx_data;
        r0 = rd_data;
        rx_q.delete();
        wr_q.delete();
        cmd_seen = 0;
        oe_cycles = 0;
        start = 1'b1;
        @(negedge clock);
        start = 1'b0;
        n = 0;
        while (busy !== 1'b0 && n < 2000) begin
            @(negedge clock);
            n++;
        end
        // Device pulses trail the master by a few clocks
        repeat (8) @(negedge clock);
        check("access end", {7'h0, busy}, 8'h00);
        check("command count", 8'(cmd_seen), 8'h01);
        check("command address", {3'h0, seen_addr}, {3'h0, cmd[7:3]});
        check("command direction", {7'h0, seen_write}, {7'h0, cmd[1]});
        check("byte count", 8'(rx_q.size()), 8'(len) + 8'h01);
        check("status slot", rx_q[0], fd ? ~cmd : cmd);
        for (int k = 1; k <= int'(len); k++) begin
            if (rd) check("read byte", rx_q[k], r0 + 8'(8'h35 * k));
            else check("write echo", rx_q[k], fd ? ZERO_BYTE : t0 + 8'(8'h29 * (k - 1)));
            if (!rd) check("write byte", wr_q[k - 1], t0 + 8'(8'h29 * (k - 1)));
        end
        check("write count", 8'(wr_q.size()), rd ? 8'h00 : 8'(len));
        check("miso use", 8'(oe_cycles > 0), {7'h0, fd});
        $display("Test done: full=%0d cpol=%0d read=%0d len=%0d", fd, pol, rd, len);
    endtask

    initial begin
        #100000;
        fails++;
        $display("ERROR watchdog expected finish seen hang");
        end_of_test();
    end

    initial begin
        rst = 1'b1;
        {start, cpol, full_duplex, read_access, duplex_wr, duplex_wdata} = 6'h00;
        {cmd_byte, status, data_len} = 20'h0;
        tx_data = 8'h5c;
        rd_data = 8'hc1;
        repeat (4) @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        check("duplex reset", {7'h0, duplex_select_bit}, {7'h0, DUPLEX_RESET});
        access(1'b0, 1'b0, 1'b1, 8'h48, 4'h2);
        access(1'b0, 1'b1, 1'b0, 8'h92, 4'h3);
        set_duplex(DUPLEX_FULL);
        access(1'b1, 1'b0, 1'b1, 8'hf8, 4'h3);
        access(1'b1, 1'b1, 1'b0, 8'h0a, 4'h2);
        access(1'b1, 1'b0, 1'b1, 8'h30, 4'h0);
        access(1'b1, 1'b1, 1'b1, 8'h00, 4'h1);
        set_duplex(1'b0);
        access(1'b0, 1'b0, 1'b0, 8'h7a, 4'h0);
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
